//--- sim/host_model.sv
// Host controller model driving the watchdog register port
`timescale 1ns/1ps
`include "wd_defines.svh"
module host_model (
   input wire logic clk_i, // Watchdog clock
   output logic wr_en_o, // Write strobe
   output logic [6:0] addr_o, // Register address
   output logic [7:0] wdata_o, // Write data
   output logic [1:0] dev_mode_o // Device mode
);
   initial begin
      wr_en_o = 1'b0;
      addr_o = 7'h00;
      wdata_o = 8'h00;
      dev_mode_o = `WD_DEV_STANDBY;
   end
   // Released bus shows the inverse, so stale data never looks valid
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1;
      wr_en_o = 1'b1;
      addr_o = a;
      wdata_o = d;
      @(posedge clk_i);
      #1;
      wr_en_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask
   task automatic trig();
      wr(`WD_ADDR_TRIG, `WD_TRIG_PATTERN);
   endtask
   // Config writes come only in Standby unless a test asks otherwise
   task automatic mode(input logic [1:0] m);
      @(posedge clk_i);
      #1;
      dev_mode_o = m;
   endtask
endmodule

//--- sim/testbench.sv
// Self-checking bench for the window watchdog
`timescale 1ns/1ps
`include "wd_defines.svh"
module testbench;
   localparam int HALF = 4;
   logic core_clk;
   logic resetn;
   logic wr_en;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic [1:0] dev_mode;
   logic rst_n;
   logic lh_out;
   logic lh_oe;
   logic lh_pin;
   logic [7:0] cfg1;
   logic [7:0] cfg2;
   logic [7:0] stat;
   int miscompares = 0;
   int check_count = 0;
   int cycles = 0;
   int n;
   int pc;
   // Open-drain pin with pull-up
   assign lh_pin = lh_oe ? lh_out : 1'b1;
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   host_model host (.clk_i(core_clk), .wr_en_o(wr_en), .addr_o(addr), .wdata_o(wdata), .dev_mode_o(dev_mode));
   window_watchdog_unit #(.HALF_MS_CYCLES(HALF), .LONG_WIN_HALVES(16'h0008)) uut (
      .core_clk_i(core_clk), .resetn_i(resetn), .wr_en_i(wr_en), .addr_i(addr), .wdata_i(wdata),
      .dev_mode_i(dev_mode), .limp_home_in_i(lh_pin), .host_reset_out_n_o(rst_n), .limp_home_out_o(lh_out),
      .limp_home_oe_o(lh_oe), .config_reg_one_o(cfg1), .config_reg_two_o(cfg2), .supervisor_status_reg_o(stat));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   task automatic wait_rst(input logic lvl, input int max, output int c);
      c = 0;
      while (rst_n !== lvl && c < max) begin
         tick(1);
         c++;
      end
   endtask
   function automatic int pulse_cycles(input logic [3:0] code);
      return (code == 4'h8 ? 2 : 8) * HALF;
   endfunction
   function automatic int period_cycles(input logic [3:0] code);
      return (code == 4'h8 ? 16 : 256) * HALF;
   endfunction
   task automatic test_done();
      $display("checks %0d, miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         test_done();
      end
   end
   initial begin
      resetn = 1'b0;
      void'($urandom(94));
      tick(3);
      resetn = 1'b1;
      chk(cfg1, `WD_CFG1_RST);
      chk(cfg2, `WD_CFG2_RST);
      chk(stat, 8'h00);
      chk({6'h00, rst_n, lh_oe}, 8'h02);
      $display("test reset values done");
      wait_rst(1'b0, 40, n);
      chk({6'h00, rst_n, lh_oe}, 8'h01);
      wait_rst(1'b1, 60, n);
      pc = pulse_cycles(4'h1);
      chk(8'(n >= pc - 4 && n <= pc + 4), 8'h01);
      chk({7'h00, lh_oe}, 8'h00);
      $display("test long window done");
      host.trig();
      host.wr(`WD_ADDR_CFG2, 8'h81);
      host.wr(`WD_ADDR_CFG2, 8'h31);
      tick(1);
      chk(cfg2, 8'h81);
      chk(stat & 8'h40, 8'h40);
      host.wr(`WD_ADDR_STAT, 8'h00);
      tick(1);
      chk(stat & 8'h40, 8'h40);
      host.wr(`WD_ADDR_STAT, 8'h40);
      tick(1);
      chk(stat & 8'h40, 8'h00);
      $display("test config write done");
      pc = period_cycles(4'h8);
      // Random spacing, always short of the period
      for (int i = 0; i < 30; i++) begin
         host.trig();
         tick($urandom_range(pc - 12, 1));
         chk({7'h00, rst_n}, 8'h01);
      end
      host.trig();
      wait_rst(1'b0, pc + 10, n);
      chk(8'(n >= pc - 8 && n <= pc + 8), 8'h01);
      tick(1);
      chk(stat & 8'h08, 8'h08);
      wait_rst(1'b1, 60, n);
      wait_rst(1'b0, 40, n);
      chk({7'h00, rst_n}, 8'h00);
      wait_rst(1'b1, 60, n);
      $display("test time-out done");
      host.trig();
      host.mode(`WD_DEV_NORMAL);
      host.wr(`WD_ADDR_CFG1, 8'h42);
      wait_rst(1'b0, 6, n);
      tick(1);
      chk({2'h0, stat[5], 4'h0, rst_n}, 8'h20);
      host.mode(`WD_DEV_STANDBY);
      wait_rst(1'b1, 60, n);
      host.trig();
      host.wr(`WD_ADDR_STAT, 8'h6E);
      tick(1);
      chk(stat & 8'h6E, 8'h00);
      $display("test illegal config done");
      host.wr(`WD_ADDR_CFG1, 8'h82);
      host.trig();
      tick(10);
      chk({7'h00, rst_n}, 8'h01);
      host.mode(`WD_DEV_NORMAL);
      tick(38);
      host.trig();
      tick(2);
      chk({3'h0, stat[4], 3'h0, rst_n}, 8'h11);
      host.trig();
      wait_rst(1'b0, 6, n);
      tick(1);
      chk({6'h00, stat[1], lh_oe}, 8'h03);
      host.mode(`WD_DEV_STANDBY);
      wait_rst(1'b1, 60, n);
      $display("test window done");
      host.trig();
      host.wr(`WD_ADDR_CFG1, 8'h22);
      tick(200);
      chk({stat[7], 6'h00, rst_n}, 8'h81);
      $display("test off mode done");
      // Time-out mode kept alive in Sleep: overflow there is the cyclic wake-up
      host.wr(`WD_ADDR_CFG1, 8'h46);
      host.trig();
      host.mode(`WD_DEV_SLEEP);
      wait_rst(1'b0, pc + 10, n);
      chk(8'(n >= pc - 8 && n <= pc + 8), 8'h01);
      tick(1);
      chk(stat & 8'h04, 8'h04);
      host.mode(`WD_DEV_STANDBY);
      wait_rst(1'b1, 60, n);
      $display("test sleep wake-up done");
      test_done();
   end
endmodule

//--- verilog/wd_defines.svh
// Watchdog register offsets, field codes and timing constants
`ifndef WD_DEFINES_SVH
`define WD_DEFINES_SVH
`define WD_ADDR_CFG1 7'h36
`define WD_ADDR_CFG2 7'h37
`define WD_ADDR_STAT 7'h38
`define WD_ADDR_TRIG 7'h39
`define WD_TRIG_PATTERN 8'h55
`define WD_CFG1_RST 8'h42
`define WD_CFG2_RST 8'h41
`define WD_MODE_OFF 3'h1
`define WD_MODE_TOUT 3'h2
`define WD_MODE_WIN 3'h4
`define WD_DEV_STANDBY 2'h0
`define WD_DEV_NORMAL 2'h1
`define WD_DEV_SLEEP 2'h2
`define WD_STAT_W1C 8'h6E
`define WD_BIT_OFF 7
`define WD_BIT_CORRUPT_WRITE_FLAG 6
`define WD_BIT_ILL 5
`define WD_BIT_TRIGS 4
`define WD_BIT_OF 3
`define WD_BIT_OFSLP 2
`define WD_BIT_ETRIG 1
`define WD_CLK_NS 20
`define WD_HALF_MS_NS 500000
`define WD_LONG_WIN_MS 256
`endif

//--- verilog/wd_pkg.sv
// Types shared by the watchdog design
package wd_pkg;
   typedef enum logic [1:0] {ST_LONG, ST_RUN, ST_PULSE} wd_state_t;
endpackage

//--- verilog/window_watchdog_unit.sv
// Window and time-out watchdog with host reset and limp-home outputs
`timescale 1ns/1ps
`include "wd_defines.svh"

module window_watchdog_unit #(
   parameter int HALF_MS_CYCLES = `WD_HALF_MS_NS / `WD_CLK_NS,
   parameter logic [15:0] LONG_WIN_HALVES = 16'(2 * `WD_LONG_WIN_MS)
) (
   input wire logic core_clk_i, // Internal oscillator clock
   input wire logic resetn_i, // Async reset, active low
   input wire logic wr_en_i, // Register write strobe
   input wire logic [6:0] addr_i, // Register address
   input wire logic [7:0] wdata_i, // Write data
   input wire logic [1:0] dev_mode_i, // Device operating mode
   input wire logic limp_home_in_i, // Limp-home pin level
   output logic host_reset_out_n_o, // Host reset, low active
   output logic limp_home_out_o, // Limp-home drive level
   output logic limp_home_oe_o, // Limp-home drive enable
   output logic [7:0] config_reg_one_o, // First config register
   output logic [7:0] config_reg_two_o, // Second config register
   output logic [7:0] supervisor_status_reg_o // Status register
);

   function automatic logic code_ok(input logic [3:0] c);
      code_ok = (c == 4'h8) || (c == 4'h1) || (c == 4'h2) || (c == 4'hB) ||
                (c == 4'h4) || (c == 4'hD) || (c == 4'hE) || (c == 4'h7);
   endfunction

   // Period in half milliseconds, so the .5 prescale factors stay exact
   function automatic logic [15:0] period_halves(input logic [3:0] c, input logic [1:0] pre);
      logic [15:0] ms;
      logic [15:0] f;
      ms = 16'h0080;
      f = 16'h0002;
      case (c)
         4'h8: ms = 16'h0008;
         4'h1: ms = 16'h0010;
         4'h2: ms = 16'h0020;
         4'hB: ms = 16'h0040;
         4'hD: ms = 16'h0100;
         4'hE: ms = 16'h0400;
         4'h7: ms = 16'h1000;
         default: ms = 16'h0080;
      endcase
      case (pre)
         2'h1: f = 16'h0003;
         2'h2: f = 16'h0005;
         2'h3: f = 16'h0007;
         default: f = 16'h0002;
      endcase
      period_halves = 16'(ms * f);
   endfunction

   // Lower bound of each pulse range, rounded up to whole half milliseconds
   function automatic logic [15:0] pulse_halves(input logic [3:0] c);
      case (c)
         4'h8: pulse_halves = 16'h0002;
         4'h2: pulse_halves = 16'h0014;
         4'hB: pulse_halves = 16'h0028;
         4'h4: pulse_halves = 16'h0050;
         4'hD: pulse_halves = 16'h0078;
         4'hE: pulse_halves = 16'h00C8;
         4'h7: pulse_halves = 16'h012C;
         default: pulse_halves = 16'h0008;
      endcase
   endfunction

   wd_pkg::wd_state_t state, next_state;
   logic [31:0] half_cnt, next_half_cnt;
   logic [15:0] timer, next_timer;
   logic [15:0] pulse, next_pulse;
   logic [7:0] cfg1, next_cfg1;
   logic [7:0] cfg2, next_cfg2;
   logic [7:0] status, next_status;
   logic host_reset_out, next_host_reset_out;
   logic lh_oe, next_lh_oe;
   logic sleep_q;
   logic tick, cfg_wr, trig, stat_wr, standby, sleep, window_act, running;
   logic cfg_bad, fire;
   logic [15:0] period, limit;

   always_comb begin
      tick = (half_cnt == 32'(HALF_MS_CYCLES - 1));
      next_half_cnt = tick ? 32'h0000_0000 : half_cnt + 32'h0000_0001;
      cfg_wr = wr_en_i && (addr_i == `WD_ADDR_CFG1 || addr_i == `WD_ADDR_CFG2);
      trig = wr_en_i && addr_i == `WD_ADDR_TRIG && wdata_i == `WD_TRIG_PATTERN;
      stat_wr = wr_en_i && addr_i == `WD_ADDR_STAT;
      standby = dev_mode_i == `WD_DEV_STANDBY;
      sleep = dev_mode_i == `WD_DEV_SLEEP;
      window_act = cfg1[7:5] == `WD_MODE_WIN && dev_mode_i == `WD_DEV_NORMAL;
      running = cfg1[7:5] != `WD_MODE_OFF && (!sleep || cfg1[2]);
      period = period_halves(cfg2[7:4], cfg1[4:3]);
      limit = (state == wd_pkg::ST_LONG) ? LONG_WIN_HALVES : period;
      if (addr_i == `WD_ADDR_CFG1) begin
         cfg_bad = !(wdata_i[7:5] == `WD_MODE_OFF || wdata_i[7:5] == `WD_MODE_TOUT ||
                     wdata_i[7:5] == `WD_MODE_WIN);
      end else begin
         cfg_bad = !code_ok(wdata_i[7:4]) || !code_ok(wdata_i[3:0]);
      end
      next_state = state;
      next_timer = timer;
      next_pulse = pulse;
      next_cfg1 = cfg1;
      next_cfg2 = cfg2;
      next_host_reset_out = host_reset_out;
      next_lh_oe = lh_oe;
      fire = 1'b0;
      // Clear first so a same-cycle event below still sets its flag
      next_status = status & ~((stat_wr ? wdata_i : 8'h00) & `WD_STAT_W1C);
      case (state)
         wd_pkg::ST_PULSE: begin
            if (tick) begin
               next_pulse = pulse - 16'h0001;
            end
            if (tick && pulse == 16'h0001) begin
               next_host_reset_out = 1'b1;
               next_lh_oe = 1'b0;
               next_timer = 16'h0000;
               next_state = cfg1[1] ? wd_pkg::ST_LONG : wd_pkg::ST_RUN;
            end
         end
         default: begin
            if (tick && (state == wd_pkg::ST_LONG || running)) begin
               next_timer = timer + 16'h0001;
            end
            if (sleep && !sleep_q && cfg1[2]) begin
               next_timer = 16'h0000;
            end
            if (cfg_wr) begin
               if (!standby) begin
                  next_status[`WD_BIT_ILL] = 1'b1;
                  fire = 1'b1;
               end else if (cfg_bad) begin
                  next_status[`WD_BIT_CORRUPT_WRITE_FLAG] = 1'b1;
               end else begin
                  if (addr_i == `WD_ADDR_CFG1) begin
                     next_cfg1 = {wdata_i[7:1], 1'b0};
                  end else begin
                     next_cfg2 = wdata_i;
                  end
                  next_timer = 16'h0000;
               end
            end else if (trig) begin
               if (state == wd_pkg::ST_LONG) begin
                  next_state = wd_pkg::ST_RUN;
                  next_timer = 16'h0000;
               end else if (window_act && timer < (period >> 1)) begin
                  next_status[`WD_BIT_ETRIG] = 1'b1;
                  fire = 1'b1;
               end else begin
                  next_timer = 16'h0000;
               end
            end else if ((state == wd_pkg::ST_LONG || running) && timer >= limit) begin
               // Sleep overflow is the cyclic wake-up: host gets a reset
               if (sleep) begin
                  next_status[`WD_BIT_OFSLP] = 1'b1;
               end else begin
                  next_status[`WD_BIT_OF] = 1'b1;
               end
               fire = 1'b1;
            end
         end
      endcase
      if (fire) begin
         next_state = wd_pkg::ST_PULSE;
         next_pulse = pulse_halves(cfg2[3:0]);
         next_host_reset_out = 1'b0;
         next_lh_oe = 1'b1;
         next_timer = 16'h0000;
      end
      next_status[`WD_BIT_OFF] = next_cfg1[7:5] == `WD_MODE_OFF;
      next_status[`WD_BIT_TRIGS] = next_state == wd_pkg::ST_RUN && window_act && next_timer < (period >> 1);
      next_status[0] = 1'b0;
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= wd_pkg::ST_LONG;
         half_cnt <= 32'h0000_0000;
         timer <= 16'h0000;
         pulse <= 16'h0000;
         cfg1 <= `WD_CFG1_RST;
         cfg2 <= `WD_CFG2_RST;
         status <= 8'h00;
         host_reset_out <= 1'b1;
         lh_oe <= 1'b0;
         sleep_q <= 1'b0;
      end else begin
         state <= next_state;
         half_cnt <= next_half_cnt;
         timer <= next_timer;
         pulse <= next_pulse;
         cfg1 <= next_cfg1;
         cfg2 <= next_cfg2;
         status <= next_status;
         host_reset_out <= next_host_reset_out;
         lh_oe <= next_lh_oe;
         sleep_q <= sleep;
      end
   end

   assign host_reset_out_n_o = host_reset_out;
   assign limp_home_oe_o = lh_oe;
   assign limp_home_out_o = 1'b0;
   assign config_reg_one_o = cfg1;
   assign config_reg_two_o = cfg2;
   assign supervisor_status_reg_o = status;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!resetn_i);

   property p_reset_lh;
      !host_reset_out_n_o |-> limp_home_oe_o;
   endproperty
   a_reset_lh: assert property (p_reset_lh) else $error("Host reset without limp-home");

   property p_illegal;
      cfg_wr && !standby && state != wd_pkg::ST_PULSE |=> status[`WD_BIT_ILL] && !host_reset_out_n_o;
   endproperty
   a_illegal: assert property (p_illegal) else $error("Illegal config not punished");

   property p_early;
      state == wd_pkg::ST_RUN && !cfg_wr && trig && window_act && timer < (period >> 1)
         |=> status[`WD_BIT_ETRIG] && !host_reset_out_n_o;
   endproperty
   a_early: assert property (p_early) else $error("Early trigger not punished");

   property p_trig;
      state == wd_pkg::ST_RUN && !cfg_wr && trig && !window_act |=> timer == 16'h0000 && host_reset_out_n_o;
   endproperty
   a_trig: assert property (p_trig) else $error("Trigger did not restart timer");

   property p_cfg_apply;
      state != wd_pkg::ST_PULSE && wr_en_i && addr_i == `WD_ADDR_CFG2 && standby && !cfg_bad
         |=> cfg2 == $past(wdata_i) && timer == 16'h0000;
   endproperty
   a_cfg_apply: assert property (p_cfg_apply) else $error("Config write not applied");

   property p_corrupt;
      state != wd_pkg::ST_PULSE && cfg_wr && standby && cfg_bad
         |=> status[`WD_BIT_CORRUPT_WRITE_FLAG] && $stable(cfg1) && $stable(cfg2);
   endproperty
   a_corrupt: assert property (p_corrupt) else $error("Corrupt write not discarded");

   property p_w1c;
      stat_wr && wdata_i[`WD_BIT_OF] && !fire |=> !status[`WD_BIT_OF];
   endproperty
   a_w1c: assert property (p_w1c) else $error("Overflow flag not cleared");

   property p_overflow;
      state == wd_pkg::ST_RUN && running && !cfg_wr && !trig && timer >= period
         |=> !host_reset_out_n_o ##1 !host_reset_out_n_o;
   endproperty
   a_overflow: assert property (p_overflow) else $error("Overflow did not reset host");

   property p_long_exit;
      state == wd_pkg::ST_LONG && !cfg_wr && trig |=> state == wd_pkg::ST_RUN && timer == 16'h0000;
   endproperty
   a_long_exit: assert property (p_long_exit) else $error("Long window not left on trigger");

endmodule
